/* File: rtl/apc_regs.sv */
// Purpose: Audio power path control register bank on AHB-Lite.
// Assumes: Single word transfers; the slave is never wait-stated.
// Notes: Outputs are decoded from the stored register bits.
//
// How it works
// - External audio reset or soft reset returns every register to default.
// - Writing one to soft reset bit resets all, itself included.
// - Power-up bit switches the whole audio function on or off.
// - Analog power bit powers up all analog audio sections.
// - Three capture bits enable capture path pairs one/two, three/four, five-eight.
// - Playback bits seven down to two enable paths one to six.
// - Playback bit one switches in the earpiece high-pass filter.
// - Two-bit field picks headset DAC and driver low power.
// - Earpiece common-mode field selects one of four driver levels.
// - Low-power bits for headset drivers, earpiece DAC, driver, offset filter.
// - Input configuration resets to 0x0f; mic power follows input select.
// - Low nibble mutes the four inputs, high nibble powers them.
// - Six digital mic enables; pair clock runs while either is enabled.
// - Fade field sets headset gain step interval 2, 0.5, 10.6, 5 ms.
// - Third ADC takes first mic input A or B; other input off.
// - Second ADC takes second mic or right line input.
// - ADC register bits five and four power headset DAC drivers.
// - Bits two, one, zero power third, first and second ADCs.
// - Seven output driver enables, earpiece through second vibrator.
// - Output register bit seven disables the pump output pull-down.
// - Seven DAC and digital path enables for the same outputs.
// - DAC register bit seven keeps pump frequency outside audio band.
`timescale 1ns/100ps
`default_nettype none

module apc_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Audio reset from the control bank, active low
    input wire logic audio_block_reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Global power
    output logic audio_power_en,
    output logic analog_power_en,
    // Digital paths
    output logic capture_pair_a_en,
    output logic capture_pair_b_en,
    output logic capture_pair_c_en,
    output logic [5:0] playback_path_en,
    output logic earpiece_highpass_en,
    // Low power and common mode
    output logic headset_driver_lowpower,
    output logic [1:0] headset_dac_lowpower_sel,
    output logic hs_dac_drivers_lowpower,
    output logic hs_dac_core_lowpower,
    output logic earpiece_dac_lowpower,
    output logic [1:0] earpiece_common_mode_sel,
    output logic headset_offset_cancel_en,
    output logic earpiece_driver_lowpower,
    // Analog inputs
    output logic first_mic_a_power,
    output logic first_mic_b_power,
    output logic second_mic_power,
    output logic line_left_power,
    output logic line_right_power,
    output logic first_mic_mute,
    output logic second_mic_mute,
    output logic line_left_mute,
    output logic line_right_mute,
    // Digital microphones
    output logic [5:0] digital_mic_active,
    output logic [2:0] digital_mic_pair_clock_en,
    output logic [1:0] headset_fade_interval,
    output logic headset_fade_step,
    // ADC routing and power
    output logic first_mic_input_select,
    output logic second_adc_input_select,
    output logic left_headset_dac_driver_en,
    output logic right_headset_dac_driver_en,
    output logic third_adc_power,
    output logic first_adc_power,
    output logic second_adc_power,
    // Outputs
    output logic pump_output_pulldown_disable,
    output logic [6:0] output_driver_en,
    output logic pump_freq_outside_band_en,
    output logic [6:0] output_dac_en
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [apc_pkg::APC_NUM_REGS-1:0][7:0] regs;
        logic wr_pend;
        logic rd_pend;
        logic [3:0] slot;
        logic slot_ok;
        logic [2:0] arst_sync;
        logic arst_level;
        logic [31:0] rdata;
    } apc_state_t;

    apc_state_t state_reg;
    apc_state_t state_next;

    function automatic logic [7:0] reg_mask(input logic [3:0] slot);
        logic [7:0] m;
        m = 8'h00;
        unique case (slot)
            4'h0: m = apc_pkg::APC_MASK_POWER_UP;
            4'h1: m = apc_pkg::APC_MASK_SOFT_RESET;
            4'h2: m = apc_pkg::APC_MASK_CAPTURE;
            4'h3: m = apc_pkg::APC_MASK_PLAYBACK;
            4'h4: m = apc_pkg::APC_MASK_LOW_POWER;
            4'h5: m = apc_pkg::APC_MASK_INPUT_CFG;
            4'h6: m = apc_pkg::APC_MASK_DMIC;
            4'h7: m = apc_pkg::APC_MASK_ADC;
            4'h8: m = apc_pkg::APC_MASK_OUT_DRV;
            4'h9: m = apc_pkg::APC_MASK_OUT_DAC;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    function automatic logic [apc_pkg::APC_NUM_REGS-1:0][7:0] defaults();
        logic [apc_pkg::APC_NUM_REGS-1:0][7:0] d;
        d = '0;
        for (int i = 0; i < apc_pkg::APC_NUM_REGS; i++) begin
            d[i] = apc_pkg::APC_RST_DEFAULT;
        end
        d[5] = apc_pkg::APC_RST_INPUT_CFG;
        return d;
    endfunction

    // -----------------------------------------------------------------
    // Bus decode and register update
    // -----------------------------------------------------------------
    logic [11:0] word_idx;
    logic [11:0] idx_off;
    logic in_range;
    logic take;
    logic bank_reset;

    assign word_idx = haddr[13:2];
    assign idx_off = word_idx - apc_pkg::APC_IDX_POWER_UP;
    assign in_range = (word_idx >= apc_pkg::APC_IDX_POWER_UP)
        && (word_idx <= apc_pkg::APC_IDX_OUT_DAC)
        && (haddr[31:14] == 18'h00000);
    assign take = hsel && hready && htrans[1];
    assign bank_reset = state_reg.arst_level
        || state_reg.regs[1][apc_pkg::APC_BIT_SOFT_RESET];

    always_comb begin
        state_next = state_reg;
        // The external reset passes three stages; it counts once two agree.
        state_next.arst_sync = {state_reg.arst_sync[1:0],
            ~audio_block_reset_n};
        if (state_reg.arst_sync[2] == state_reg.arst_sync[1]) begin
            state_next.arst_level = state_reg.arst_sync[2];
        end
        state_next.wr_pend = 1'b0;
        state_next.rd_pend = 1'b0;
        if (take) begin
            state_next.wr_pend = hwrite;
            state_next.rd_pend = !hwrite;
            state_next.slot = idx_off[3:0];
            state_next.slot_ok = in_range;
        end
        if (state_reg.wr_pend && state_reg.slot_ok) begin
            state_next.regs[state_reg.slot] =
                hwdata[7:0] & reg_mask(state_reg.slot);
        end
        state_next.rdata = 32'h00000000;
        if (take && !hwrite && in_range) begin
            state_next.rdata = {24'h000000,
                state_reg.regs[idx_off[3:0]] & reg_mask(idx_off[3:0])};
        end
        if (bank_reset) begin
            state_next.regs = defaults();
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.regs <= defaults();
        end else begin
            state_reg <= state_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;

    // -----------------------------------------------------------------
    // Decoded controls
    // -----------------------------------------------------------------
    logic [7:0] r_pwr;
    logic [7:0] r_cap;
    logic [7:0] r_pb;
    logic [7:0] r_lp;
    logic [7:0] r_in;
    logic [7:0] r_dm;
    logic [7:0] r_adc;
    logic [7:0] r_drv;
    logic [7:0] r_dac;

    assign r_pwr = state_reg.regs[0];
    assign r_cap = state_reg.regs[2];
    assign r_pb = state_reg.regs[3];
    assign r_lp = state_reg.regs[4];
    assign r_in = state_reg.regs[5];
    assign r_dm = state_reg.regs[6];
    assign r_adc = state_reg.regs[7];
    assign r_drv = state_reg.regs[8];
    assign r_dac = state_reg.regs[9];

    assign audio_power_en = r_pwr[apc_pkg::APC_BIT_POWER_UP];
    assign analog_power_en = r_pwr[apc_pkg::APC_BIT_ANALOG];
    assign capture_pair_a_en = r_cap[apc_pkg::APC_BIT_CAP_A];
    assign capture_pair_b_en = r_cap[apc_pkg::APC_BIT_CAP_B];
    assign capture_pair_c_en = r_cap[apc_pkg::APC_BIT_CAP_C];
    assign playback_path_en = r_pb[7:2];
    assign earpiece_highpass_en = r_pb[apc_pkg::APC_BIT_EAR_HP];
    assign headset_dac_lowpower_sel = r_lp[6:5];
    assign hs_dac_drivers_lowpower = r_lp[5];
    assign hs_dac_core_lowpower = r_lp[6];
    assign earpiece_common_mode_sel = r_lp[3:2];
    assign headset_driver_lowpower = r_lp[apc_pkg::APC_BIT_HS_DRV_LP];
    assign earpiece_dac_lowpower = r_lp[apc_pkg::APC_BIT_EAR_DAC_LP];
    assign headset_offset_cancel_en = r_lp[apc_pkg::APC_BIT_HS_OFS];
    assign earpiece_driver_lowpower = r_lp[apc_pkg::APC_BIT_EAR_DRV_LP];
    assign first_mic_input_select = r_adc[apc_pkg::APC_BIT_MIC1_SEL];
    assign first_mic_a_power = r_in[7] && !first_mic_input_select;
    assign first_mic_b_power = r_in[7] && first_mic_input_select;
    assign second_mic_power = r_in[6];
    assign line_left_power = r_in[5];
    assign line_right_power = r_in[4];
    assign first_mic_mute = r_in[3];
    assign second_mic_mute = r_in[2];
    assign line_left_mute = r_in[1];
    assign line_right_mute = r_in[0];
    assign digital_mic_active = r_dm[7:2];
    assign digital_mic_pair_clock_en = {r_dm[7] | r_dm[6],
        r_dm[5] | r_dm[4], r_dm[3] | r_dm[2]};
    assign headset_fade_interval = r_dm[1:0];
    assign second_adc_input_select = r_adc[apc_pkg::APC_BIT_ADC2_SEL];
    assign left_headset_dac_driver_en = r_adc[5];
    assign right_headset_dac_driver_en = r_adc[4];
    assign third_adc_power = r_adc[2];
    assign first_adc_power = r_adc[1];
    assign second_adc_power = r_adc[0];
    assign output_driver_en = r_drv[6:0];
    assign pump_output_pulldown_disable = r_drv[apc_pkg::APC_BIT_TOP];
    assign output_dac_en = r_dac[6:0];
    assign pump_freq_outside_band_en = r_dac[apc_pkg::APC_BIT_TOP];

    apc_fade_tick u_fade (
        .clock(clock),
        .rst(rst),
        .run(audio_power_en),
        .interval_sel(r_dm[1:0]),
        .step_tick(headset_fade_step)
    );

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    property p_soft_reset_clears;
        @(posedge clock) disable iff (rst)
        (state_reg.wr_pend && state_reg.slot_ok && state_reg.slot == 4'h1
            && hwdata[7] && !state_reg.arst_level)
        |=> ##1 (state_reg.regs[1] == 8'h00
            && state_reg.regs[5] == apc_pkg::APC_RST_INPUT_CFG);
    endproperty
    a_soft_reset_clears: assert property (p_soft_reset_clears)
        else $error("soft reset did not restore defaults");

    property p_ext_reset;
        @(posedge clock) disable iff (rst)
        state_reg.arst_level |=> (r_pwr == 8'h00 && r_in == 8'h0f
            && r_dac == 8'h00);
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("audio reset left a register set");

    property p_power_bit;
        @(posedge clock) disable iff (rst)
        (state_reg.wr_pend && state_reg.slot_ok && state_reg.slot == 4'h0
            && !bank_reset) |=> audio_power_en == $past(hwdata[7]);
    endproperty
    a_power_bit: assert property (p_power_bit)
        else $error("power bit did not follow the write");

    property p_reserved_zero;
        @(posedge clock) disable iff (rst)
        (r_pwr & 8'h77) == 8'h00 && (r_cap & 8'h57) == 8'h00
            && r_pb[0] == 1'b0 && r_adc[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit holds a one");

    property p_mic_exclusive;
        @(posedge clock) disable iff (rst)
        !(first_mic_a_power && first_mic_b_power)
            && (first_mic_a_power || first_mic_b_power) == r_in[7];
    endproperty
    a_mic_exclusive: assert property (p_mic_exclusive)
        else $error("first mic input selection wrong");

    property p_pair_clock;
        @(posedge clock) disable iff (rst)
        digital_mic_pair_clock_en[2] == (digital_mic_active[5]
            || digital_mic_active[4]);
    endproperty
    a_pair_clock: assert property (p_pair_clock)
        else $error("pair clock does not follow its inputs");

    property p_read_back;
        @(posedge clock) disable iff (rst)
        (take && !hwrite && in_range && word_idx == apc_pkg::APC_IDX_DMIC)
        |=> hrdata == {24'h000000, $past(r_dm)};
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data does not match the register");

    property p_unmapped_read;
        @(posedge clock) disable iff (rst)
        (take && !in_range) |=> hrdata == 32'h00000000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero data");

endmodule

`default_nettype wire

/* File: inc/apc_pkg.sv */
// Purpose: Shared constants for the audio power path control register bank.
// Assumes: AHB-Lite slave with 32-bit data, one register per aligned word.
// Notes: Register indices are kept; byte address is four times the index.
package apc_pkg;

    // -----------------------------------------------------------------
    // Register indices and write masks
    // -----------------------------------------------------------------
    localparam logic [11:0] APC_IDX_POWER_UP = 12'hd00;
    localparam logic [11:0] APC_IDX_SOFT_RESET = 12'hd01;
    localparam logic [11:0] APC_IDX_CAPTURE = 12'hd02;
    localparam logic [11:0] APC_IDX_PLAYBACK = 12'hd03;
    localparam logic [11:0] APC_IDX_LOW_POWER = 12'hd04;
    localparam logic [11:0] APC_IDX_INPUT_CFG = 12'hd05;
    localparam logic [11:0] APC_IDX_DMIC = 12'hd06;
    localparam logic [11:0] APC_IDX_ADC = 12'hd07;
    localparam logic [11:0] APC_IDX_OUT_DRV = 12'hd08;
    localparam logic [11:0] APC_IDX_OUT_DAC = 12'hd09;
    localparam int APC_NUM_REGS = 10;

    localparam logic [7:0] APC_MASK_POWER_UP = 8'h88;
    localparam logic [7:0] APC_MASK_SOFT_RESET = 8'h80;
    localparam logic [7:0] APC_MASK_CAPTURE = 8'ha8;
    localparam logic [7:0] APC_MASK_PLAYBACK = 8'hfe;
    localparam logic [7:0] APC_MASK_LOW_POWER = 8'hff;
    localparam logic [7:0] APC_MASK_INPUT_CFG = 8'hff;
    localparam logic [7:0] APC_MASK_DMIC = 8'hff;
    localparam logic [7:0] APC_MASK_ADC = 8'hf7;
    localparam logic [7:0] APC_MASK_OUT_DRV = 8'hff;
    localparam logic [7:0] APC_MASK_OUT_DAC = 8'hff;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] APC_RST_DEFAULT = 8'h00;
    localparam logic [7:0] APC_RST_INPUT_CFG = 8'h0f;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int APC_BIT_POWER_UP = 7;
    localparam int APC_BIT_ANALOG = 3;
    localparam int APC_BIT_SOFT_RESET = 7;
    localparam int APC_BIT_CAP_A = 7;
    localparam int APC_BIT_CAP_B = 5;
    localparam int APC_BIT_CAP_C = 3;
    localparam int APC_BIT_EAR_HP = 1;
    localparam int APC_BIT_HS_DRV_LP = 7;
    localparam int APC_BIT_EAR_DAC_LP = 4;
    localparam int APC_BIT_HS_OFS = 1;
    localparam int APC_BIT_EAR_DRV_LP = 0;
    localparam int APC_BIT_MIC1_SEL = 7;
    localparam int APC_BIT_ADC2_SEL = 6;
    localparam int APC_BIT_TOP = 7;

    // -----------------------------------------------------------------
    // Headset fade interval, in microseconds, and cycles at 50 MHz
    // -----------------------------------------------------------------
    localparam int APC_CLK_KHZ = 50000;
    localparam int APC_FADE_US_00 = 2000;
    localparam int APC_FADE_US_01 = 500;
    localparam int APC_FADE_US_10 = 10600;
    localparam int APC_FADE_US_11 = 5000;
    localparam int APC_FADE_CYC_00 = APC_FADE_US_00 * APC_CLK_KHZ / 1000;
    localparam int APC_FADE_CYC_01 = APC_FADE_US_01 * APC_CLK_KHZ / 1000;
    localparam int APC_FADE_CYC_10 = APC_FADE_US_10 * APC_CLK_KHZ / 1000;
    localparam int APC_FADE_CYC_11 = APC_FADE_US_11 * APC_CLK_KHZ / 1000;
    localparam int APC_FADE_W = 20;

endpackage

/* File: rtl/apc_fade_tick.sv */
// Purpose: Produces the headset gain step tick from the fade interval field.
// Assumes: Interval counts are given in clock cycles by the parameters.
// Notes: A change of the field restarts the interval.
`timescale 1ns/100ps
`default_nettype none

module apc_fade_tick #(
    parameter logic [19:0] CYC_00 = 20'(apc_pkg::APC_FADE_CYC_00),
    parameter logic [19:0] CYC_01 = 20'(apc_pkg::APC_FADE_CYC_01),
    parameter logic [19:0] CYC_10 = 20'(apc_pkg::APC_FADE_CYC_10),
    parameter logic [19:0] CYC_11 = 20'(apc_pkg::APC_FADE_CYC_11)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [1:0] interval_sel,
    // Tick
    output logic step_tick
);

    typedef struct packed {
        logic [19:0] count;
        logic [1:0] sel;
        logic tick;
    } apc_fade_state_t;

    apc_fade_state_t state_reg;
    apc_fade_state_t state_next;
    logic [19:0] limit;

    always_comb begin
        unique case (interval_sel)
            2'b00: limit = CYC_00;
            2'b01: limit = CYC_01;
            2'b10: limit = CYC_10;
            2'b11: limit = CYC_11;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        state_next.sel = interval_sel;
        if (!run || interval_sel != state_reg.sel) begin
            state_next.count = 20'h00000;
        end else if (state_reg.count >= limit - 20'h00001) begin
            state_next.count = 20'h00000;
            state_next.tick = 1'b1;
        end else begin
            state_next.count = state_reg.count + 20'h00001;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign step_tick = state_reg.tick;

endmodule

`default_nettype wire

/* File: testbench/apc_regs_bench.sv */
// Purpose: Self-checking bench for the audio power path register bank.
// Assumes: The slave never wait-states; hready is fed back from hreadyout.
// Notes: Expected outputs are decoded here from a register image.
`timescale 1ns/100ps
`default_nettype none

module apc_regs_bench;
    logic clock, rst, audio_block_reset_n, hsel, hwrite, hready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, headset_dac_lowpower_sel, earpiece_common_mode_sel;
    logic [2:0] hsize, digital_mic_pair_clock_en;
    logic hreadyout, hresp, audio_power_en, analog_power_en;
    logic capture_pair_a_en, capture_pair_b_en, capture_pair_c_en;
    logic [5:0] playback_path_en, digital_mic_active;
    logic earpiece_highpass_en, headset_driver_lowpower;
    logic hs_dac_drivers_lowpower, hs_dac_core_lowpower;
    logic earpiece_dac_lowpower, headset_offset_cancel_en;
    logic earpiece_driver_lowpower, first_mic_a_power, first_mic_b_power;
    logic second_mic_power, line_left_power, line_right_power;
    logic first_mic_mute, second_mic_mute, line_left_mute, line_right_mute;
    logic [1:0] headset_fade_interval;
    logic headset_fade_step, first_mic_input_select, second_adc_input_select;
    logic left_headset_dac_driver_en, right_headset_dac_driver_en;
    logic third_adc_power, first_adc_power, second_adc_power;
    logic pump_output_pulldown_disable, pump_freq_outside_band_en;
    logic [6:0] output_driver_en, output_dac_en;
    logic [7:0] img [10];
    int errors, compares;

    apc_regs u_dut (.*);
    assign hready = hreadyout;

    // -----------------------------------------------------------------
    // Clock
    // -----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] ad(int i);
        return {18'h0, apc_pkg::APC_IDX_POWER_UP + 12'(i), 2'b00};
    endfunction

    function automatic logic [7:0] msk(int i);
        case (i)
            0: return apc_pkg::APC_MASK_POWER_UP;
            1: return apc_pkg::APC_MASK_SOFT_RESET;
            2: return apc_pkg::APC_MASK_CAPTURE;
            3: return apc_pkg::APC_MASK_PLAYBACK;
            7: return apc_pkg::APC_MASK_ADC;
            default: return 8'hff;
        endcase
    endfunction

    // One single transfer; the answer is awaited, never assumed.
    task automatic bus(logic wr, logic [31:0] a, logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do begin
            @(posedge clock);
        end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do begin
            @(posedge clock);
        end while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic set_defaults;
        foreach (img[i]) begin
            img[i] = (i == 5) ? apc_pkg::APC_RST_INPUT_CFG
                              : apc_pkg::APC_RST_DEFAULT;
        end
    endtask

    task automatic chk_outs;
        chk("power", {audio_power_en, analog_power_en, hresp,
            hreadyout}, {img[0][7], img[0][3], 1'b0, 1'b1});
        chk("paths", {capture_pair_a_en, capture_pair_b_en,
            capture_pair_c_en, playback_path_en, earpiece_highpass_en},
            {img[2][7], img[2][5], img[2][3], img[3][7:1]});
        chk("lowpower", {headset_driver_lowpower,
            headset_dac_lowpower_sel, earpiece_dac_lowpower,
            earpiece_common_mode_sel, headset_offset_cancel_en,
            earpiece_driver_lowpower, hs_dac_core_lowpower,
            hs_dac_drivers_lowpower}, {img[4], img[4][6:5]});
        chk("inputs", {first_mic_a_power, first_mic_b_power,
            second_mic_power, line_left_power, line_right_power,
            first_mic_mute, second_mic_mute, line_left_mute,
            line_right_mute}, {img[5][7] & ~img[7][7],
            img[5][7] & img[7][7], img[5][6:0]});
        chk("dmic", {digital_mic_active, headset_fade_interval,
            digital_mic_pair_clock_en}, {img[6], img[6][7] | img[6][6],
            img[6][5] | img[6][4], img[6][3] | img[6][2]});
        chk("adc", {first_mic_input_select, second_adc_input_select,
            left_headset_dac_driver_en, right_headset_dac_driver_en,
            third_adc_power, first_adc_power, second_adc_power},
            {img[7][7:4], img[7][2:0]});
        chk("outputs", {pump_output_pulldown_disable,
            output_driver_en, pump_freq_outside_band_en, output_dac_en},
            {img[8], img[9]});
    endtask

    task automatic read_all;
        logic [31:0] q;
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, ad(i), 8'h00, q);
            chk("register", q, {24'h0, img[i]});
        end
        chk_outs();
    endtask

    task automatic fill(logic [7:0] pat, int step);
        logic [31:0] q;
        logic [7:0] d;
        for (int i = 0; i < 10; i++) begin
            d = pat ^ 8'(i * step);
            if (i == 1) begin
                d = d & 8'h7f;
            end
            img[i] = d & msk(i);
            bus(1'b1, ad(i), d, q);
        end
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_patterns;
        for (int p = 0; p < 4; p++) begin
            fill((p == 3) ? 8'hff : 8'(8'h53 * p), (p == 3) ? 0 : 8'h1d);
            read_all();
        end
        $display("test patterns done");
    endtask

    task automatic t_unmapped;
        logic [31:0] q;
        bus(1'b1, ad(10), 8'hff, q);
        bus(1'b1, ad(-1), 8'hff, q);
        bus(1'b0, ad(10), 8'h00, q);
        chk("unmapped", q, 32'h0);
        bus(1'b0, ad(-1), 8'h00, q);
        chk("unmapped", q, 32'h0);
        bus(1'b1, ad(7), 8'h77, q);
        img[7] = 8'h77 & msk(7);
        read_all();
        $display("test unmapped done");
    endtask

    task automatic t_soft_reset;
        logic [31:0] q;
        fill(8'hff, 0);
        bus(1'b1, ad(1), 8'h80, q);
        set_defaults();
        read_all();
        $display("test soft reset done");
    endtask

    task automatic t_ext_reset;
        logic [31:0] q;
        fill(8'ha5, 8'h31);
        audio_block_reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        set_defaults();
        chk_outs();
        bus(1'b1, ad(0), 8'hff, q);
        repeat (2) @(posedge clock);
        chk_outs();
        audio_block_reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        read_all();
        $display("test external reset done");
    endtask

    task automatic t_fade;
        logic [31:0] q;
        int n;
        bus(1'b1, ad(6), 8'h01, q);
        bus(1'b1, ad(0), 8'h80, q);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (headset_fade_step !== 1'b1 && n < 30000);
        end
        chk("fade", 32'(n), 32'(apc_pkg::APC_FADE_CYC_01));
        $display("test fade done");
    endtask

    // -----------------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        errors = 0;
        compares = 0;
        rst = 1'b1;
        audio_block_reset_n = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        set_defaults();
        read_all();
        $display("test reset values done");
        t_patterns();
        t_unmapped();
        t_soft_reset();
        t_ext_reset();
        t_fade();
        end_sim();
    end

    initial begin
        repeat (80000) @(posedge clock);
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
